// *** core/dpfc_pkg.sv ***
// Package of constants for the digital port and function input block
package dpfc_pkg;
   localparam int unsigned PORT_A_WIDTH = 8;
   localparam int unsigned PORT_B_WIDTH = 4;
   localparam int unsigned LINE_COUNT = 12;
   localparam int unsigned COUNT_WIDTH = 32;
   // Values after reset, and the counter step
   localparam logic [11:0] DIR_RESET = 12'h000;
   localparam logic [11:0] OUT_RESET = 12'hfff;
   localparam logic [11:0] DRIVE_RESET = 12'h000;
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
   // Function input modes
   localparam logic [1:0] FUNC_OFF = 2'h0;
   localparam logic [1:0] FUNC_TRIGGER = 2'h1;
   localparam logic [1:0] FUNC_COUNTER = 2'h2;
   // Trigger state codes, one-hot
   typedef enum logic [2:0] {
      DPFC_IDLE = 3'h1,
      DPFC_ARMED = 3'h2,
      DPFC_RUN = 3'h4
   } dpfc_trig_e;
endpackage

// *** core/dpfc_line.sv ***
// One port line: direction, driver type, static output and input capture
`timescale 1ns/1ps
module dpfc_line (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic dir_in,
   input wire logic push_pull_in,
   input wire logic wr_in,
   input wire logic wr_data_in,
   input wire logic rd_in,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_out,
   output logic rd_data_out
);
   logic dir_reg, dir_next;
   logic pp_reg, pp_next;
   logic lvl_reg, lvl_next;
   logic cap_reg, cap_next;

   // Next values: writes land only on a host strobe
   always_comb begin
      dir_next = wr_in ? dir_in : dir_reg;
      pp_next = wr_in ? push_pull_in : pp_reg;
      lvl_next = wr_in ? wr_data_in : lvl_reg;
      cap_next = rd_in ? pin_in : cap_reg;
   end

   // Reset leaves line an undriven input
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         dir_reg <= dpfc_pkg::DIR_RESET[0];
         pp_reg <= dpfc_pkg::DRIVE_RESET[0];
         lvl_reg <= dpfc_pkg::OUT_RESET[0];
         cap_reg <= 1'b0;
      end else begin
         dir_reg <= dir_next;
         pp_reg <= pp_next;
         lvl_reg <= lvl_next;
         cap_reg <= cap_next;
      end
   end

   // Open collector only pulls low; push-pull drives both levels
   assign pin_out = lvl_reg;
   assign pin_oe_out = dir_reg & (pp_reg | ~lvl_reg);
   assign rd_data_out = cap_reg;

   // Released line never driven
   line_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !dir_reg |-> !pin_oe_out) else $error("input line driven");
   // Open collector never drives high
   open_coll_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (dir_reg && !pp_reg && lvl_reg) |-> !pin_oe_out)
      else $error("open collector drove high");
   // Read captures the pin one edge later
   read_cap_a: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_in |=> rd_data_out == $past(pin_in))
      else $error("read capture wrong");
endmodule

// *** core/dpfc_top.sv ***
// Digital port with function input trigger, event counter, supply enable
`timescale 1ns/1ps
module dpfc_top #(
   parameter bit HAS_PUSH_PULL = 1'b1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // Host static access
   input wire logic [11:0] dir_in,
   input wire logic [11:0] push_pull_in,
   input wire logic port_wr_in,
   input wire logic [11:0] port_wr_data_in,
   input wire logic port_rd_in,
   output logic [11:0] static_input_out,
   // Pins
   input wire logic [7:0] port_a_lines_in,
   output logic [7:0] port_a_lines_out,
   output logic [7:0] port_a_lines_oe_out,
   input wire logic [3:0] port_b_lines_in,
   output logic [3:0] port_b_lines_out,
   output logic [3:0] port_b_lines_oe_out,
   input wire logic function_input_in,
   // Function input control
   input wire logic [1:0] func_mode_in,
   input wire logic trig_enable_in,
   input wire logic task_start_in,
   input wire logic task_stop_in,
   output logic acquisition_start_trigger_out,
   output logic acq_run_out,
   output logic [31:0] event_count_out,
   // Supply
   input wire logic usb_suspend_in,
   output logic aux_supply_en_out
);
   // ****************************************************************
   // Port lines
   // ****************************************************************
   logic [11:0] pin_in_w, pin_out_w, pin_oe_w;
   logic [11:0] pp_eff;

   assign pin_in_w = {port_b_lines_in, port_a_lines_in};
   // Lower variant forces open collector on every line
   assign pp_eff = HAS_PUSH_PULL ? push_pull_in : 12'h000;

   // One line cell per terminal
   genvar gi;
   generate
      for (gi = 0; gi < dpfc_pkg::LINE_COUNT; gi++) begin : g_line
         dpfc_line u_line (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .dir_in(dir_in[gi]),
            .push_pull_in(pp_eff[gi]),
            .wr_in(port_wr_in),
            .wr_data_in(port_wr_data_in[gi]),
            .rd_in(port_rd_in),
            .pin_in(pin_in_w[gi]),
            .pin_out(pin_out_w[gi]),
            .pin_oe_out(pin_oe_w[gi]),
            .rd_data_out(static_input_out[gi])
         );
      end
   endgenerate

   assign port_a_lines_out = pin_out_w[7:0];
   assign port_a_lines_oe_out = pin_oe_w[7:0];
   assign port_b_lines_out = pin_out_w[11:8];
   assign port_b_lines_oe_out = pin_oe_w[11:8];

   // ****************************************************************
   // Function input edge detect
   // ****************************************************************
   logic fin_reg, fin_next;
   logic rise_w, fall_w;

   // Input is already synchronous, one stage of history is enough
   always_comb begin
      fin_next = function_input_in;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         fin_reg <= 1'b0;
      end else begin
         fin_reg <= fin_next;
      end
   end

   assign rise_w = function_input_in & ~fin_reg;
   assign fall_w = ~function_input_in & fin_reg;

   // ****************************************************************
   // Start trigger state machine
   // ****************************************************************
   dpfc_pkg::dpfc_trig_e st_reg, st_next;
   logic trig_mode_w;
   logic trig_pulse_reg, trig_pulse_next;

   assign trig_mode_w = (func_mode_in == dpfc_pkg::FUNC_TRIGGER)
                        && trig_enable_in;

   // Task start arms or runs; rising edge releases armed task
   always_comb begin
      st_next = st_reg;
      trig_pulse_next = 1'b0;
      case (st_reg)
         dpfc_pkg::DPFC_IDLE: begin
            if (task_start_in) begin
               st_next = trig_mode_w ? dpfc_pkg::DPFC_ARMED
                                     : dpfc_pkg::DPFC_RUN;
            end
         end
         dpfc_pkg::DPFC_ARMED: begin
            if (task_stop_in) begin
               st_next = dpfc_pkg::DPFC_IDLE;
            end else if (rise_w) begin
               st_next = dpfc_pkg::DPFC_RUN;
               trig_pulse_next = 1'b1;
            end
         end
         dpfc_pkg::DPFC_RUN: begin
            if (task_stop_in) begin
               st_next = dpfc_pkg::DPFC_IDLE;
            end
         end
         default: st_next = dpfc_pkg::DPFC_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg <= dpfc_pkg::DPFC_IDLE;
         trig_pulse_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         trig_pulse_reg <= trig_pulse_next;
      end
   end

   assign acq_run_out = (st_reg == dpfc_pkg::DPFC_RUN);
   assign acquisition_start_trigger_out = trig_pulse_reg;

   // ****************************************************************
   // Falling edge event counter
   // ****************************************************************
   logic [31:0] cnt_reg, cnt_next;
   logic cnt_mode_w;

   assign cnt_mode_w = (func_mode_in == dpfc_pkg::FUNC_COUNTER);

   // Start clears; otherwise wrap is natural modulo arithmetic
   always_comb begin
      cnt_next = cnt_reg;
      if (task_start_in) begin
         cnt_next = dpfc_pkg::COUNT_RESET;
      end else if (cnt_mode_w && fall_w) begin
         cnt_next = cnt_reg + dpfc_pkg::COUNT_STEP;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_reg <= dpfc_pkg::COUNT_RESET;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign event_count_out = cnt_reg;

   // ****************************************************************
   // Auxiliary supply enable
   // ****************************************************************
   logic sup_reg, sup_next;

   // Registered so the enable never glitches on the pin
   always_comb begin
      sup_next = ~usb_suspend_in;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sup_reg <= 1'b0;
      end else begin
         sup_reg <= sup_next;
      end
   end

   assign aux_supply_en_out = sup_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Armed state holds until a rising edge or stop
   trig_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg == dpfc_pkg::DPFC_ARMED && !rise_w && !task_stop_in)
      |=> st_reg == dpfc_pkg::DPFC_ARMED)
      else $error("armed task left early");
   // Rising edge while armed starts run with one pulse
   trig_fire_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (st_reg == dpfc_pkg::DPFC_ARMED && rise_w && !task_stop_in)
      |=> acq_run_out && acquisition_start_trigger_out)
      else $error("trigger did not start run");
   // Each falling edge in count mode adds one
   count_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (cnt_mode_w && fall_w && !task_start_in)
      |=> event_count_out == $past(event_count_out) + 32'h0000_0001)
      else $error("count did not step");
   // No counted edge, no change; edges in other modes are ignored
   count_still_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (!(cnt_mode_w && fall_w) && !task_start_in)
      |=> $stable(event_count_out))
      else $error("count moved without edge");
   // Task start clears count
   count_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      task_start_in |=> event_count_out == 32'h0000_0000)
      else $error("count not cleared");
   // Suspend drops the supply from its second cycle on
   supply_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
      usb_suspend_in[*2] |-> !aux_supply_en_out)
      else $error("supply on in suspend");
   // Resume restores the supply one edge later
   supply_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(usb_suspend_in) |=> aux_supply_en_out)
      else $error("supply not restored");
   // Write with input direction drives nothing next cycle
   port_input_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (port_wr_in && dir_in == 12'h000) |=> pin_oe_w == 12'h000)
      else $error("input port driven");
endmodule

// *** sim/dpfc_ext_model.sv ***
// Outside circuits on the port lines: sources, switches and the pull-ups
`timescale 1ns/1ps
module dpfc_ext_model (
   input wire logic [11:0] oe_in,
   input wire logic [11:0] out_in,
   input wire logic [11:0] drive_en_in,
   input wire logic [11:0] drive_val_in,
   output logic [11:0] level_out
);
   // ****************************************
   // Wire level of each line
   // ****************************************
   // Sources back off where the device drives, so no line is fought over
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         if (oe_in[i]) level_out[i] = out_in[i];
         else if (drive_en_in[i]) level_out[i] = drive_val_in[i];
         else level_out[i] = 1'b1; // Weak pull-up wins when released
      end
   end
endmodule

// *** sim/dio_port_with_pfi_counter_tb_top.sv ***
// Testbench for the digital port, function input and supply enable
`timescale 1ns/1ps
module dio_port_with_pfi_counter_tb_top;
   logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, fi = 1'b0;
   logic [11:0] dir = '0, pp = '0, wdata = '0, drv_en = '0, drv_val = '0;
   logic [11:0] lvl, rdata, oe, lo;
   logic [7:0] a_out, a_oe;
   logic [3:0] b_out, b_oe;
   logic [7:0] oc_a_oe;
   logic [3:0] oc_b_oe;
   logic [1:0] mode = 2'h0;
   logic ten = 1'b0, start = 1'b0, stop = 1'b0, susp = 1'b0;
   logic trig, run, sup;
   logic [31:0] cnt;
   int num_errors = 0, comparisons = 0;
   assign oe = {b_oe, a_oe};
   assign lo = {b_out, a_out};
   // ****************************************
   // Design, outside circuits and clock
   // ****************************************
   dpfc_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .dir_in(dir),
      .push_pull_in(pp), .port_wr_in(wr), .port_wr_data_in(wdata),
      .port_rd_in(rd), .static_input_out(rdata),
      .port_a_lines_in(lvl[7:0]), .port_a_lines_out(a_out),
      .port_a_lines_oe_out(a_oe), .port_b_lines_in(lvl[11:8]),
      .port_b_lines_out(b_out), .port_b_lines_oe_out(b_oe),
      .function_input_in(fi), .func_mode_in(mode), .trig_enable_in(ten),
      .task_start_in(start), .task_stop_in(stop),
      .acquisition_start_trigger_out(trig), .acq_run_out(run),
      .event_count_out(cnt), .usb_suspend_in(susp),
      .aux_supply_en_out(sup));
   dpfc_ext_model ext_u (.oe_in(oe), .out_in(lo), .drive_en_in(drv_en),
      .drive_val_in(drv_val), .level_out(lvl));
   // Lower variant shares every input; only its enables are compared
   dpfc_top #(
      .HAS_PUSH_PULL(1'b0)
   ) dut_oc_u (.clk_in(clk_in), .rst_in(rst_in), .dir_in(dir),
      .push_pull_in(pp), .port_wr_in(wr), .port_wr_data_in(wdata),
      .port_rd_in(rd), .static_input_out(),
      .port_a_lines_in(lvl[7:0]), .port_a_lines_out(),
      .port_a_lines_oe_out(oc_a_oe), .port_b_lines_in(lvl[11:8]),
      .port_b_lines_out(), .port_b_lines_oe_out(oc_b_oe),
      .function_input_in(fi), .func_mode_in(mode), .trig_enable_in(ten),
      .task_start_in(start), .task_stop_in(stop),
      .acquisition_start_trigger_out(), .acq_run_out(),
      .event_count_out(), .usb_suspend_in(susp),
      .aux_supply_en_out());
   always #2 clk_in = ~clk_in;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [31:0] got, exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Strobes last one cycle; results are looked at one falling edge later
   task automatic port_write(input logic [11:0] d, p, v);
      @(negedge clk_in);
      dir = d;
      pp = p;
      wdata = v;
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
   endtask
   task automatic port_read(output logic [11:0] v);
      @(negedge clk_in);
      rd = 1'b1;
      @(negedge clk_in);
      rd = 1'b0;
      v = rdata;
   endtask
   // Falling edges on the function input, each level held two cycles
   task automatic falls(input int n);
      repeat (n) begin
         @(negedge clk_in);
         fi = 1'b1;
         repeat (2) @(negedge clk_in);
         fi = 1'b0;
         @(negedge clk_in);
      end
      repeat (2) @(negedge clk_in);
   endtask
   // One-cycle control pulse: stop when is_stop is set, start otherwise
   task automatic pulse(input logic is_stop);
      @(negedge clk_in);
      if (is_stop) begin
         stop = 1'b1;
      end else begin
         start = 1'b1;
      end
      @(negedge clk_in);
      start = 1'b0;
      stop = 1'b0;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [11:0] r;
      int k;
      repeat (12) @(negedge clk_in);
      rst_in = 1'b0;
      check(oe, 12'h000, "lines driven after reset");
      port_read(r);
      check(r, 12'hfff, "released lines not high");
      drv_en = 12'hfff;
      drv_val = 12'ha5c;
      port_read(r);
      check(r, 12'ha5c, "static read of inputs");
      $display("test reset_and_inputs done");
      drv_en = 12'hf0f;
      port_write(12'h0f0, 12'h000, 12'h050);
      check(oe, 12'h0a0, "open collector enables");
      port_read(r);
      check(r, 12'ha5c & 12'hf0f | 12'h050, "mixed directions");
      port_write(12'h0f0, 12'hfff, 12'h050);
      check(oe, 12'h0f0, "push-pull enables");
      check(lo & oe, 12'h050, "push-pull levels");
      check({oc_b_oe, oc_a_oe}, 12'h0a0, "lower variant pushed");
      drv_en = 12'h000;
      port_write(12'hfff, 12'h000, 12'h3c3);
      port_write(12'hfff, 12'h0ff, 12'h3c3); // Two writes one idle cycle apart
      check(oe, 12'hc3c | 12'h0ff, "per-line drive type");
      check({oc_b_oe, oc_a_oe}, 12'hc3c, "lower variant types");
      port_read(r);
      check(r, 12'h3c3, "output levels on wires");
      port_write(12'h000, 12'h000, 12'h000);
      check(oe, 12'h000, "return to input");
      $display("test static_port done");
      mode = 2'h1;
      ten = 1'b1;
      pulse(1'b0);
      repeat (4) @(negedge clk_in);
      check({trig, run}, 2'b00, "run before rising edge");
      fi = 1'b1;
      k = 0;
      while (trig !== 1'b1 && k < 5) begin
         @(negedge clk_in); k++;
      end
      check({trig, run}, 2'b11, "trigger on rising edge");
      @(negedge clk_in);
      check({trig, run}, 2'b01, "trigger pulse length");
      pulse(1'b1);
      @(negedge clk_in);
      check(run, 1'b0, "stop returns to idle");
      $display("test trigger done");
      mode = 2'h2;
      ten = 1'b0;
      pulse(1'b0);
      @(negedge clk_in);
      check(cnt, 32'h0, "count cleared on start");
      check(run, 1'b1, "untriggered start did not run");
      falls(5);
      check(cnt, 32'h5, "falling edges counted");
      mode = 2'h0;
      falls(2);
      check(cnt, 32'h5, "counted while off");
      mode = 2'h2;
      pulse(1'b1);
      pulse(1'b0);
      @(negedge clk_in);
      check(cnt, 32'h0, "count cleared on new task");
      pulse(1'b1);
      $display("test counter done");
      check(sup, 1'b1, "supply off while awake");
      susp = 1'b1;
      repeat (2) @(negedge clk_in);
      check(sup, 1'b0, "supply on in suspend");
      susp = 1'b0;
      repeat (2) @(negedge clk_in);
      check(sup, 1'b1, "supply not back on resume");
      $display("test supply done");
      print_verdict();
   end
   // Whole run is under a hundred cycles; give it ample margin
   initial begin
      #40000;
      num_errors++;
      print_verdict();
   end
endmodule
